//--- logic/isfm_monitor.sv
// Input scaling, fault supervision and shutdown log with APB registers
// Behaviour
// - Equation scaling: a divided by b, times input minus c
// - Coefficients a, b, c clamped to plus/minus 10000
// - Simple current input uses gain 1250 over 1000
// - Current input type switches in the measurement shunt
// - Simple mode default; equation mode uses coefficients
// - Log ready loss while enabled, last ten kept
// - Shutdown log is volatile, cleared at reset
// - Log lists newest last; empty slots read dashes
// - Supervise only when supervision is on or auto, except the parameter error
// - Command loop out of range turns output off
// - Feedback loop out of range turns output off
// - Solenoid wiring fault disables the power stage
// - Power-up parameter error holds output until saved
// - Process variables always readable for monitoring
`timescale 1ns/1ps
module isfm_monitor (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic signed [15:0] raw_input_value,
  input wire logic signed [15:0] fb_raw_value,
  input wire logic signed [15:0] output_level,
  input wire logic signed [15:0] solenoid_current,
  input wire logic enable_pin,
  input wire logic solenoid_fault_pin,
  input wire logic param_error_pin,
  output logic shunt_cmd_en,
  output logic shunt_fb_en,
  output logic output_enable,
  output logic power_stage_enable,
  output logic ready,
  output logic irq
);
  typedef struct packed {
    isfm_pkg::isfm_mode_e scaling_mode_select;
    isfm_pkg::isfm_sup_e fault_supervision_setting;
    logic type_cmd;
    logic type_fb;
    logic [isfm_pkg::EV_W-1:0] irq_stat;
    logic [isfm_pkg::EV_W-1:0] irq_mask;
    logic signed [15:0] cmd_a;
    logic signed [15:0] cmd_b;
    logic signed [15:0] cmd_c;
    logic signed [15:0] fb_a;
    logic signed [15:0] fb_b;
    logic signed [15:0] fb_c;
    logic signed [15:0] pv_in;
    logic signed [15:0] pv_fb_raw;
    logic signed [15:0] pv_cmd;
    logic signed [15:0] pv_fb;
    logic signed [15:0] pv_err;
    logic signed [15:0] pv_out;
    logic signed [15:0] pv_sol;
    logic [isfm_pkg::CAUSE_W-1:0] fault;
    logic param_err;
    logic [1:0] catch_cnt;
    logic ready;
    logic out_en;
    logic stage_en;
    logic [9:0][isfm_pkg::CAUSE_W-1:0] log_slot;
    logic [3:0] log_cnt;
    logic rdy;
    logic slverr;
    logic [31:0] rdata;
  } isfm_state_s;

  isfm_state_s s_reg;
  isfm_state_s s_next;
  logic [2:0] pins_s;
  logic en_s;
  logic sol_s;
  logic param_s;
  logic signed [15:0] cmd_scaled;
  logic signed [15:0] fb_scaled;

  function automatic logic signed [15:0] clamp_coef(input logic [31:0] v);
    logic signed [31:0] sv;
    sv = $signed(v);
    if (sv > 32'(isfm_pkg::COEF_MAX)) begin
      return isfm_pkg::COEF_MAX;
    end
    if (sv < 32'(isfm_pkg::COEF_MIN)) begin
      return isfm_pkg::COEF_MIN;
    end
    return sv[15:0];
  endfunction

  function automatic logic [31:0] sx(input logic [15:0] v);
    return {{16{v[15]}}, v};
  endfunction

  function automatic logic is_log(input logic [7:0] a);
    return (a >= isfm_pkg::OFF_LOG_BASE) &&
      (a < isfm_pkg::OFF_LOG_BASE + isfm_pkg::LOG_SPAN) &&
      (a[1:0] == 2'h0);
  endfunction

  function automatic logic is_mapped(input logic [7:0] a);
    unique case (a)
      isfm_pkg::OFF_CTRL, isfm_pkg::OFF_STATUS,
      isfm_pkg::OFF_IRQ_STAT, isfm_pkg::OFF_IRQ_MASK,
      isfm_pkg::OFF_CMD_A, isfm_pkg::OFF_CMD_B, isfm_pkg::OFF_CMD_C,
      isfm_pkg::OFF_FB_A, isfm_pkg::OFF_FB_B, isfm_pkg::OFF_FB_C,
      isfm_pkg::OFF_PV_IN, isfm_pkg::OFF_PV_CMD, isfm_pkg::OFF_PV_FB,
      isfm_pkg::OFF_PV_ERR, isfm_pkg::OFF_LOG_COUNT,
      isfm_pkg::OFF_PV_OUT, isfm_pkg::OFF_PV_SOL: return 1'b1;
      default: return is_log(a);
    endcase
  endfunction

  isfm_sync #(
    .W(3)
  ) u_pin_sync (
    .pclk(pclk),
    .presetn(presetn),
    .d({param_error_pin, solenoid_fault_pin, enable_pin}),
    .q(pins_s)
  );

  assign en_s = pins_s[0];
  assign sol_s = pins_s[1];
  assign param_s = pins_s[2];

  isfm_scaler u_cmd_scaler (
    .mode(s_reg.scaling_mode_select),
    .current_sel(s_reg.type_cmd),
    .raw(s_reg.pv_in),
    .coef_a(s_reg.cmd_a),
    .coef_b(s_reg.cmd_b),
    .coef_c(s_reg.cmd_c),
    .scaled(cmd_scaled)
  );

  isfm_scaler u_fb_scaler (
    .mode(s_reg.scaling_mode_select),
    .current_sel(s_reg.type_fb),
    .raw(s_reg.pv_fb_raw),
    .coef_a(s_reg.fb_a),
    .coef_b(s_reg.fb_b),
    .coef_c(s_reg.fb_c),
    .scaled(fb_scaled)
  );

  always_comb begin
    logic setup;
    logic done;
    logic wr;
    logic rd_clr;
    logic sup_on;
    logic shut;
    logic [isfm_pkg::CAUSE_W-1:0] cause;
    logic [isfm_pkg::EV_W-1:0] ev;
    logic [3:0] idx;
    logic armed;
    setup = psel && !penable;
    done = psel && penable && s_reg.rdy;
    wr = done && pwrite && !s_reg.slverr;
    rd_clr = done && !pwrite && (paddr == isfm_pkg::OFF_IRQ_STAT);
    // Outputs stay off until the power-up parameter check has been taken
    armed = &s_reg.catch_cnt;
    s_next = s_reg;
    idx = 4'h0;

    // Process variables sampled every cycle
    s_next.pv_in = raw_input_value;
    s_next.pv_fb_raw = fb_raw_value;
    s_next.pv_cmd = cmd_scaled;
    s_next.pv_fb = fb_scaled;
    s_next.pv_err = 16'(cmd_scaled - fb_scaled);
    s_next.pv_out = output_level;
    s_next.pv_sol = solenoid_current;

    sup_on = (s_reg.fault_supervision_setting == isfm_pkg::SUP_ON) ||
      (s_reg.fault_supervision_setting == isfm_pkg::SUP_AUTO);
    cause = '0;
    cause[isfm_pkg::CAUSE_CMD] = sup_on && s_reg.type_cmd &&
      ((s_reg.pv_in < isfm_pkg::LOOP_MIN) ||
       (s_reg.pv_in > isfm_pkg::LOOP_MAX));
    cause[isfm_pkg::CAUSE_FB] = sup_on && s_reg.type_fb &&
      ((s_reg.pv_fb_raw < isfm_pkg::LOOP_MIN) ||
       (s_reg.pv_fb_raw > isfm_pkg::LOOP_MAX));
    cause[isfm_pkg::CAUSE_SOL] = sup_on && sol_s;
    cause[isfm_pkg::CAUSE_PARAM] = s_reg.param_err;
    s_next.fault = cause;

    s_next.ready = armed && (cause == '0);
    s_next.out_en = armed && (cause == '0) && en_s;
    s_next.stage_en = armed && !cause[isfm_pkg::CAUSE_SOL] &&
      !cause[isfm_pkg::CAUSE_PARAM] && en_s;

    // Ready about to fall while enabled counts as a shutdown
    shut = s_reg.ready && (cause != '0) && en_s;
    if (shut) begin
      for (int i = 0; i < 9; i++) begin
        s_next.log_slot[i] = s_reg.log_slot[i + 1];
      end
      s_next.log_slot[9] = cause;
      if (s_reg.log_cnt != isfm_pkg::LOG_DEPTH) begin
        s_next.log_cnt = s_reg.log_cnt + 4'h1;
      end
    end

    ev = {cause & ~s_reg.fault, shut};
    // Only bits already returned by the read are cleared; new events win
    s_next.irq_stat = (rd_clr ?
      s_reg.irq_stat & ~s_reg.rdata[isfm_pkg::EV_W-1:0] :
      s_reg.irq_stat) | ev;

    if (wr) begin
      unique case (paddr)
        isfm_pkg::OFF_CTRL: begin
          s_next.scaling_mode_select =
            isfm_pkg::isfm_mode_e'(pwdata[isfm_pkg::CTRL_MODE]);
          s_next.fault_supervision_setting = isfm_pkg::isfm_sup_e'(
            pwdata[isfm_pkg::CTRL_SUP_HI:isfm_pkg::CTRL_SUP_LO]);
          s_next.type_cmd = pwdata[isfm_pkg::CTRL_TYPE_CMD];
          s_next.type_fb = pwdata[isfm_pkg::CTRL_TYPE_FB];
          if (pwdata[isfm_pkg::CTRL_SAVE]) begin
            s_next.param_err = 1'b0;
          end
        end
        isfm_pkg::OFF_IRQ_MASK: s_next.irq_mask = pwdata[4:0];
        isfm_pkg::OFF_CMD_A: s_next.cmd_a = clamp_coef(pwdata);
        isfm_pkg::OFF_CMD_B: s_next.cmd_b = clamp_coef(pwdata);
        isfm_pkg::OFF_CMD_C: s_next.cmd_c = clamp_coef(pwdata);
        isfm_pkg::OFF_FB_A: s_next.fb_a = clamp_coef(pwdata);
        isfm_pkg::OFF_FB_B: s_next.fb_b = clamp_coef(pwdata);
        isfm_pkg::OFF_FB_C: s_next.fb_c = clamp_coef(pwdata);
        default: begin
        end
      endcase
    end

    // Parameter check result is caught once, just after reset release
    if (s_reg.catch_cnt < isfm_pkg::CATCH_CYCLES) begin
      s_next.catch_cnt = s_reg.catch_cnt + 2'h1;
    end else if (s_reg.catch_cnt == isfm_pkg::CATCH_CYCLES) begin
      if (param_s) begin
        s_next.param_err = 1'b1;
      end
      s_next.catch_cnt = 2'h3;
    end

    s_next.rdy = setup;
    s_next.slverr = setup && !is_mapped(paddr);
    s_next.rdata = '0;
    if (setup) begin
      unique case (paddr)
        isfm_pkg::OFF_CTRL: begin
          s_next.rdata[isfm_pkg::CTRL_MODE] = s_reg.scaling_mode_select;
          s_next.rdata[isfm_pkg::CTRL_SUP_HI:isfm_pkg::CTRL_SUP_LO] =
            s_reg.fault_supervision_setting;
          s_next.rdata[isfm_pkg::CTRL_TYPE_CMD] = s_reg.type_cmd;
          s_next.rdata[isfm_pkg::CTRL_TYPE_FB] = s_reg.type_fb;
        end
        isfm_pkg::OFF_STATUS: begin
          s_next.rdata[isfm_pkg::ST_CAUSE_HI:0] = s_reg.fault;
          s_next.rdata[isfm_pkg::ST_READY] = s_reg.ready;
          s_next.rdata[isfm_pkg::ST_OUT] = s_reg.out_en;
          s_next.rdata[isfm_pkg::ST_STAGE] = s_reg.stage_en;
          s_next.rdata[isfm_pkg::ST_EN] = en_s;
        end
        isfm_pkg::OFF_IRQ_STAT: s_next.rdata[4:0] = s_reg.irq_stat;
        isfm_pkg::OFF_IRQ_MASK: s_next.rdata[4:0] = s_reg.irq_mask;
        isfm_pkg::OFF_CMD_A: s_next.rdata = sx(s_reg.cmd_a);
        isfm_pkg::OFF_CMD_B: s_next.rdata = sx(s_reg.cmd_b);
        isfm_pkg::OFF_CMD_C: s_next.rdata = sx(s_reg.cmd_c);
        isfm_pkg::OFF_FB_A: s_next.rdata = sx(s_reg.fb_a);
        isfm_pkg::OFF_FB_B: s_next.rdata = sx(s_reg.fb_b);
        isfm_pkg::OFF_FB_C: s_next.rdata = sx(s_reg.fb_c);
        isfm_pkg::OFF_PV_IN: s_next.rdata = sx(s_reg.pv_in);
        isfm_pkg::OFF_PV_CMD: s_next.rdata = sx(s_reg.pv_cmd);
        isfm_pkg::OFF_PV_FB: s_next.rdata = sx(s_reg.pv_fb);
        isfm_pkg::OFF_PV_ERR: s_next.rdata = sx(s_reg.pv_err);
        isfm_pkg::OFF_PV_OUT: s_next.rdata = sx(s_reg.pv_out);
        isfm_pkg::OFF_PV_SOL: s_next.rdata = sx(s_reg.pv_sol);
        isfm_pkg::OFF_LOG_COUNT: s_next.rdata[3:0] = s_reg.log_cnt;
        default: begin
          if (is_log(paddr)) begin
            idx = 4'((paddr - isfm_pkg::OFF_LOG_BASE) >> 2);
            // Oldest sits lowest, newest in the last slot
            if (idx >= isfm_pkg::LOG_DEPTH - s_reg.log_cnt) begin
              s_next.rdata[3:0] = s_reg.log_slot[idx];
            end else begin
              s_next.rdata = isfm_pkg::LOG_EMPTY;
            end
          end
        end
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_reg <= '0;
      s_reg.fault_supervision_setting <= isfm_pkg::SUP_ON;
      s_reg.scaling_mode_select <= isfm_pkg::MODE_SIMPLE;
      s_reg.irq_mask <= isfm_pkg::MASK_RESET;
      s_reg.cmd_a <= isfm_pkg::EQ_A_RESET;
      s_reg.cmd_b <= isfm_pkg::EQ_B_RESET;
      s_reg.cmd_c <= isfm_pkg::EQ_C_RESET;
      s_reg.fb_a <= isfm_pkg::EQ_A_RESET;
      s_reg.fb_b <= isfm_pkg::EQ_B_RESET;
      s_reg.fb_c <= isfm_pkg::EQ_C_RESET;
    end else begin
      s_reg <= s_next;
    end
  end

  assign prdata = s_reg.rdata;
  assign pready = s_reg.rdy;
  assign pslverr = s_reg.slverr;
  assign shunt_cmd_en = s_reg.type_cmd;
  assign shunt_fb_en = s_reg.type_fb;
  assign output_enable = s_reg.out_en;
  assign power_stage_enable = s_reg.stage_en;
  assign ready = s_reg.ready;
  assign irq = |(s_reg.irq_stat & s_reg.irq_mask);
endmodule // isfm_monitor

//--- include/isfm_pkg.sv
// Constants and types shared by the input scaling and fault monitor
package isfm_pkg;
  localparam int ADDR_W = 8;
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_STATUS = 8'h04;
  localparam logic [7:0] OFF_IRQ_STAT = 8'h08;
  localparam logic [7:0] OFF_IRQ_MASK = 8'h0C;
  localparam logic [7:0] OFF_CMD_A = 8'h10;
  localparam logic [7:0] OFF_CMD_B = 8'h14;
  localparam logic [7:0] OFF_CMD_C = 8'h18;
  localparam logic [7:0] OFF_FB_A = 8'h1C;
  localparam logic [7:0] OFF_FB_B = 8'h20;
  localparam logic [7:0] OFF_FB_C = 8'h24;
  localparam logic [7:0] OFF_PV_IN = 8'h30;
  localparam logic [7:0] OFF_PV_CMD = 8'h34;
  localparam logic [7:0] OFF_PV_FB = 8'h38;
  localparam logic [7:0] OFF_PV_ERR = 8'h3C;
  localparam logic [7:0] OFF_LOG_BASE = 8'h40;
  localparam logic [7:0] LOG_SPAN = 8'h28;
  localparam logic [7:0] OFF_LOG_COUNT = 8'h68;
  localparam logic [7:0] OFF_PV_OUT = 8'h70;
  localparam logic [7:0] OFF_PV_SOL = 8'h74;
  localparam int CTRL_MODE = 0;
  localparam int CTRL_SUP_LO = 1;
  localparam int CTRL_SUP_HI = 2;
  localparam int CTRL_TYPE_CMD = 3;
  localparam int CTRL_TYPE_FB = 4;
  localparam int CTRL_SAVE = 5;
  localparam int ST_CAUSE_HI = 3;
  localparam int ST_READY = 4;
  localparam int ST_OUT = 5;
  localparam int ST_STAGE = 6;
  localparam int ST_EN = 7;
  localparam int EV_SHUTDOWN = 0;
  localparam int EV_W = 5;
  localparam int CAUSE_W = 4;
  localparam int CAUSE_CMD = 0;
  localparam int CAUSE_FB = 1;
  localparam int CAUSE_SOL = 2;
  localparam int CAUSE_PARAM = 3;
  localparam logic [3:0] LOG_DEPTH = 4'hA;
  localparam logic [31:0] LOG_EMPTY = 32'h002D2D2D;
  localparam logic [1:0] CATCH_CYCLES = 2'h2;
  localparam logic signed [15:0] COEF_MAX = 16'sh2710;
  localparam logic signed [15:0] COEF_MIN = 16'shD8F0;
  localparam logic signed [15:0] EQ_A_RESET = 16'sh03E8;
  localparam logic signed [15:0] EQ_B_RESET = 16'sh03E8;
  localparam logic signed [15:0] EQ_C_RESET = 16'sh0000;
  localparam logic signed [15:0] SIMPLE_V_A = 16'sh03E8;
  localparam logic signed [15:0] SIMPLE_V_B = 16'sh03E8;
  localparam logic signed [15:0] SIMPLE_V_C = 16'sh0000;
  localparam logic signed [15:0] SIMPLE_C_A = 16'sh04E2;
  localparam logic signed [15:0] SIMPLE_C_B = 16'sh03E8;
  localparam logic signed [15:0] SIMPLE_C_C = 16'sh07D0;
  localparam logic signed [15:0] LOOP_MIN = 16'sh0708;
  localparam logic signed [15:0] LOOP_MAX = 16'sh2904;
  localparam logic signed [32:0] SAT_MAX = 33'sh0_0000_7FFF;
  localparam logic signed [32:0] SAT_MIN = 33'sh1_FFFF_8000;
  localparam logic [EV_W-1:0] MASK_RESET = 5'h00;
  typedef enum logic {
    MODE_SIMPLE = 1'b0,
    MODE_EQUATION = 1'b1
  } isfm_mode_e;
  typedef enum logic [1:0] {
    SUP_OFF = 2'b00,
    SUP_ON = 2'b01,
    SUP_AUTO = 2'b11
  } isfm_sup_e;
endpackage

//--- logic/isfm_sync.sv
// Two-stage synchroniser for asynchronous pins
`timescale 1ns/1ps
module isfm_sync #(
  parameter int W = 1
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  typedef struct packed {
    logic [W-1:0] meta;
    logic [W-1:0] stable;
  } isfm_sync_s;

  isfm_sync_s sync_reg, sync_next;

  always_comb begin
    sync_next.meta = d;
    sync_next.stable = sync_reg.meta;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync_reg <= '0;
    end else begin
      sync_reg <= sync_next;
    end
  end

  assign q = sync_reg.stable;
endmodule // isfm_sync

//--- logic/isfm_scaler.sv
// Gain and offset scaling of one analog input
`timescale 1ns/1ps
module isfm_scaler (
  input wire isfm_pkg::isfm_mode_e mode,
  input wire logic current_sel,
  input wire logic signed [15:0] raw,
  input wire logic signed [15:0] coef_a,
  input wire logic signed [15:0] coef_b,
  input wire logic signed [15:0] coef_c,
  output logic signed [15:0] scaled
);
  logic signed [15:0] ka;
  logic signed [15:0] kb;
  logic signed [15:0] kc;
  logic signed [16:0] diff;
  logic signed [32:0] prod;
  logic signed [32:0] quo;

  always_comb begin
    if (mode == isfm_pkg::MODE_EQUATION) begin
      ka = coef_a;
      kb = coef_b;
      kc = coef_c;
    end else if (current_sel) begin
      ka = isfm_pkg::SIMPLE_C_A;
      kb = isfm_pkg::SIMPLE_C_B;
      kc = isfm_pkg::SIMPLE_C_C;
    end else begin
      ka = isfm_pkg::SIMPLE_V_A;
      kb = isfm_pkg::SIMPLE_V_B;
      kc = isfm_pkg::SIMPLE_V_C;
    end
    diff = 17'(raw) - 17'(kc);
    prod = 33'(ka) * 33'(diff);
    quo = '0;
    if (kb != 16'sh0000) begin
      quo = prod / 33'(kb);
    end
    if (kb == 16'sh0000) begin
      scaled = 16'sh0000;
    end else if (quo > isfm_pkg::SAT_MAX) begin
      scaled = 16'sh7FFF;
    end else if (quo < isfm_pkg::SAT_MIN) begin
      scaled = 16'sh8000;
    end else begin
      scaled = quo[15:0];
    end
  end
endmodule // isfm_scaler

//--- dv/isfm_chk_monitor.sv
// Port checker for the scaling and fault monitor
`timescale 1ns/1ps
module isfm_chk (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic enable_pin,
  input wire logic solenoid_fault_pin,
  input wire logic shunt_cmd_en,
  input wire logic shunt_fb_en,
  input wire logic output_enable,
  input wire logic power_stage_enable,
  input wire logic ready
);
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  // Shadow of the supervision field, taken from completed control writes
  logic [1:0] sup_seen;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sup_seen <= isfm_pkg::SUP_ON;
    end else if (psel && penable && pready && pwrite && !pslverr &&
      paddr == isfm_pkg::OFF_CTRL) begin
      sup_seen <= pwdata[isfm_pkg::CTRL_SUP_HI:isfm_pkg::CTRL_SUP_LO];
    end
  end
  sequence s_setup;
    psel && !penable;
  endsequence
  sequence s_ctrl_wr;
    psel && penable && pready && pwrite && paddr == 8'h00;
  endsequence
  sequence s_sol_held;
    solenoid_fault_pin [*6];
  endsequence
  AST_PREADY:
    assert property (s_setup |=> pready)
    else $error("no answer one cycle after setup");
  AST_ONE_WAIT:
    assert property (pready |=> !pready)
    else $error("pready held beyond one cycle");
  AST_ERR:
    assert property (pslverr |-> pready && penable)
    else $error("error flag outside access cycle");
  AST_SHUNT_CMD:
    assert property (s_ctrl_wr |=>
      shunt_cmd_en == $past(pwdata[isfm_pkg::CTRL_TYPE_CMD]))
    else $error("command shunt not following control");
  AST_SHUNT_FB:
    assert property (s_ctrl_wr |=>
      shunt_fb_en == $past(pwdata[isfm_pkg::CTRL_TYPE_FB]))
    else $error("feedback shunt not following control");
  AST_SOL:
    assert property ((sup_seen[0] throughout s_sol_held) |->
      !power_stage_enable)
    else $error("power stage on with wiring fault");
  AST_OUT_READY:
    assert property (output_enable |-> ready && power_stage_enable)
    else $error("output on without ready");
  AST_EN_OFF:
    assert property (!enable_pin [*6] |-> !output_enable)
    else $error("output on without enable");
endmodule // isfm_chk
bind isfm_monitor isfm_chk isfm_chk_i (.pclk, .presetn, .psel, .penable,
  .pwrite, .paddr, .pwdata, .pready, .pslverr, .enable_pin,
  .solenoid_fault_pin, .shunt_cmd_en, .shunt_fb_en, .output_enable,
  .power_stage_enable, .ready);

//--- dv/isfm_plant.sv
// Far-side model: loop sources and solenoid wiring
`timescale 1ns/1ps
module isfm_plant (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic signed [15:0] cmd_set,
  input wire logic signed [15:0] fb_set,
  input wire logic cmd_break,
  input wire logic sol_break,
  input wire logic output_enable,
  input wire logic power_stage_enable,
  output logic signed [15:0] raw_input_value,
  output logic signed [15:0] fb_raw_value,
  output logic signed [15:0] output_level,
  output logic signed [15:0] solenoid_current,
  output logic solenoid_fault_pin
);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      raw_input_value <= 16'sh0000;
      fb_raw_value <= 16'sh0000;
      output_level <= 16'sh0000;
      solenoid_current <= 16'sh0000;
      solenoid_fault_pin <= 1'b0;
    end else begin
      // A broken loop carries no current at all
      raw_input_value <= cmd_break ? 16'sh0000 : cmd_set;
      fb_raw_value <= fb_set;
      output_level <= output_enable ? cmd_set : 16'sh0000;
      solenoid_current <= power_stage_enable ? output_level : 16'sh0000;
      solenoid_fault_pin <= sol_break;
    end
  end
endmodule // isfm_plant

//--- dv/tb.sv
// Self-checking bench for the scaling and fault monitor
`timescale 1ns/1ps
module tb;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic signed [15:0] raw_input_value, fb_raw_value, cmd_set, fb_set;
  logic signed [15:0] output_level, solenoid_current;
  logic enable_pin, solenoid_fault_pin, param_error_pin, err;
  logic shunt_cmd_en, shunt_fb_en, output_enable, power_stage_enable;
  logic ready, irq, cmd_break, sol_break;
  int fail_count, tests_run;
  isfm_monitor isfm_monitor_i (.pclk, .presetn, .psel, .penable,
    .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .raw_input_value, .fb_raw_value, .output_level, .solenoid_current,
    .enable_pin, .solenoid_fault_pin, .param_error_pin, .shunt_cmd_en,
    .shunt_fb_en, .output_enable, .power_stage_enable, .ready, .irq);
  isfm_plant isfm_plant_i (.pclk, .presetn, .cmd_set, .fb_set,
    .cmd_break, .sol_break, .output_enable, .power_stage_enable,
    .raw_input_value, .fb_raw_value, .output_level, .solenoid_current,
    .solenoid_fault_pin);
  initial begin
    pclk = 1'b0;
    forever #20 pclk = ~pclk;
  end
  task automatic end_sim;
    $display("comparisons %0d mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      fail_count++;
      $display("unexpected at %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic bchk(input logic got, input logic exp);
    chk({31'h0, got}, {31'h0, exp});
  endtask
  task automatic apb(input logic w, input logic [7:0] a,
    input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
    if (n >= 20) begin
      fail_count++;
      end_sim();
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(rd, e);
  endtask
  task automatic settle;
    repeat (8) @(posedge pclk);
  endtask
  task automatic wait_rdy(input logic v);
    int n;
    n = 0;
    while (ready !== v && n < 30) begin
      @(posedge pclk);
      n++;
    end
    if (n >= 30) begin
      fail_count++;
      end_sim();
    end
    settle();
  endtask
  task automatic do_reset(input logic perr);
    presetn <= 1'b0;
    param_error_pin <= perr;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    settle();
  endtask
  task automatic t_regs;
    rdc(8'h00, 32'h2);
    rdc(8'h0C, 32'h0);
    rdc(8'h10, 32'h3E8);
    rdc(8'h20, 32'h3E8);
    rdc(8'h04, 32'h10);
    rdc(8'h68, 32'h0);
    rdc(8'h40, isfm_pkg::LOG_EMPTY);
    wr(8'h68, 32'h5);
    rdc(8'h68, 32'h0);
    rdc(8'hFC, 32'h0);
    bchk(err, 1'b1);
    $display("t_regs done");
  endtask
  task automatic t_scale;
    enable_pin <= 1'b1;
    cmd_set <= 16'sh1388;
    fb_set <= 16'sh0BB8;
    settle();
    rdc(8'h30, 32'h1388);
    rdc(8'h34, 32'h1388);
    rdc(8'h3C, 32'h7D0);
    rdc(8'h70, 32'h1388);
    rdc(8'h74, 32'h1388);
    wr(8'h00, 32'h0A);
    bchk(shunt_cmd_en, 1'b1);
    settle();
    rdc(8'h34, 32'hEA6);
    wr(8'h00, 32'h03);
    wr(8'h10, 32'h4E20);
    rdc(8'h10, 32'h2710);
    wr(8'h18, 32'hFFFFB1E0);
    rdc(8'h18, 32'hFFFFD8F0);
    wr(8'h10, 32'h7D0);
    wr(8'h18, 32'h3E8);
    settle();
    rdc(8'h34, 32'h1F40);
    wr(8'h10, 32'hFFFFF448);
    settle();
    rdc(8'h34, 32'hFFFFD120);
    wr(8'h14, 32'h0);
    settle();
    rdc(8'h34, 32'h0);
    wr(8'h10, 32'h3E8);
    wr(8'h14, 32'h3E8);
    wr(8'h18, 32'h0);
    wr(8'h00, 32'h02);
    $display("t_scale done");
  endtask
  task automatic t_loop;
    wr(8'h0C, 32'h1F);
    wr(8'h00, 32'h0A);
    apb(1'b0, 8'h08, 32'h0);
    cmd_break <= 1'b1;
    wait_rdy(1'b0);
    bchk(output_enable, 1'b0);
    bchk(irq, 1'b1);
    rdc(8'h04, 32'hC1);
    rdc(8'h08, 32'h03);
    bchk(irq, 1'b0);
    rdc(8'h68, 32'h1);
    rdc(8'h64, 32'h1);
    cmd_break <= 1'b0;
    wait_rdy(1'b1);
    wr(8'h0C, 32'h0);
    wr(8'h00, 32'h12);
    bchk(shunt_fb_en, 1'b1);
    bchk(shunt_cmd_en, 1'b0);
    fb_set <= 16'sh2EE0;
    wait_rdy(1'b0);
    bchk(output_enable, 1'b0);
    bchk(irq, 1'b0);
    wr(8'h0C, 32'h1F);
    bchk(irq, 1'b1);
    apb(1'b0, 8'h08, 32'h0);
    bchk(irq, 1'b0);
    rdc(8'h64, 32'h2);
    rdc(8'h60, 32'h1);
    rdc(8'h5C, isfm_pkg::LOG_EMPTY);
    fb_set <= 16'sh0BB8;
    wait_rdy(1'b1);
    enable_pin <= 1'b0;
    fb_set <= 16'sh2EE0;
    wait_rdy(1'b0);
    rdc(8'h68, 32'h2);
    fb_set <= 16'sh0BB8;
    enable_pin <= 1'b1;
    wait_rdy(1'b1);
    $display("t_loop done");
  endtask
  task automatic t_ten;
    wr(8'h00, 32'h0A);
    for (int i = 0; i < 10; i++) begin
      cmd_break <= 1'b1;
      wait_rdy(1'b0);
      cmd_break <= 1'b0;
      wait_rdy(1'b1);
    end
    rdc(8'h68, {28'h0, isfm_pkg::LOG_DEPTH});
    rdc(8'h40, 32'h1);
    $display("t_ten done");
  endtask
  task automatic t_sup;
    logic [7:0] sc [3] = '{8'h08, 8'h0C, 8'h0E};
    logic sr [3] = '{1'b1, 1'b1, 1'b0};
    for (int i = 0; i < 3; i++) begin
      wr(8'h00, {24'h0, sc[i]});
      cmd_break <= 1'b1;
      settle();
      bchk(ready, sr[i]);
      cmd_break <= 1'b0;
      wait_rdy(1'b1);
    end
    $display("t_sup done");
  endtask
  task automatic t_sol;
    wr(8'h00, 32'h02);
    sol_break <= 1'b1;
    wait_rdy(1'b0);
    bchk(power_stage_enable, 1'b0);
    rdc(8'h04, 32'h84);
    sol_break <= 1'b0;
    wait_rdy(1'b1);
    bchk(power_stage_enable, 1'b1);
    $display("t_sol done");
  endtask
  task automatic t_param;
    do_reset(1'b1);
    rdc(8'h68, 32'h0);
    bchk(ready, 1'b0);
    rdc(8'h04, 32'h88);
    param_error_pin <= 1'b0;
    settle();
    bchk(output_enable, 1'b0);
    wr(8'h00, 32'h22);
    wait_rdy(1'b1);
    bchk(output_enable, 1'b1);
    $display("t_param done");
  endtask
  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    cmd_set = 16'sh0000;
    fb_set = 16'sh0000;
    cmd_break = 1'b0;
    sol_break = 1'b0;
    enable_pin = 1'b0;
    param_error_pin = 1'b0;
    fail_count = 0;
    tests_run = 0;
    do_reset(1'b0);
    t_regs();
    t_scale();
    t_loop();
    t_ten();
    t_sup();
    t_sol();
    t_param();
    end_sim();
  end
endmodule // tb
